// >>> hdl/pwt_pkg.sv
package pwt_pkg;

  // byte of a frame that the receiver is expecting
  localparam logic [1:0] PH_ADDR = 2'h0;
  localparam logic [1:0] PH_CMD  = 2'h1;
  localparam logic [1:0] PH_DATA = 2'h2;

  // register addresses carried in the command byte
  localparam logic [3:0] REG_WIPER0 = 4'h0;
  localparam logic [3:0] REG_WIPER1 = 4'h1;
  localparam logic [3:0] REG_TERMINAL_CONTROL_REG   = 4'h4;

  // operations carried in the command byte
  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [1:0] OP_INCR  = 2'h1;
  localparam logic [1:0] OP_DECR  = 2'h2;
  localparam logic [1:0] OP_READ  = 2'h3;

  // command byte field positions
  localparam int CMD_ADDR_HI = 7;
  localparam int CMD_ADDR_LO = 4;
  localparam int CMD_OP_HI   = 3;
  localparam int CMD_OP_LO   = 2;
  localparam int CMD_DATA_HI = 1;

  // terminal-control nibble of each network
  localparam int TC_TERM_B = 0;
  localparam int TC_WIPER  = 1;
  localparam int TC_TERM_A = 2;
  localparam int TC_HW_N   = 3;
  localparam int TC_NIBBLE = 4;

  localparam logic [7:0] TERMINAL_CONTROL_REG_RESET    = 8'hFF;
  localparam int         WIPER_W       = 10;
  localparam logic [9:0] WIPER_RESET_8 = 10'h080;
  localparam logic [9:0] WIPER_RESET_7 = 10'h040;

  // edge after reset at which a0_lat_q takes the synchronised a0, one edge after it first shows the pin level
  localparam logic [1:0] A0_CAPTURE_AT = 2'h3;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX   = 5'h02,
    ST_ACK  = 5'h04,
    ST_TX   = 5'h08,
    ST_MACK = 5'h10
  } pwt_state_t;

endpackage

// >>> hdl/pwt_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pwt_sync #(
  parameter int unsigned      W   = 1,
  parameter logic [W-1:0]     RST = '1
) (
  input  wire logic         i_clk,   // system clock
  input  wire logic         i_rst_n, // async reset, active low
  input  wire logic [W-1:0] i_d,     // asynchronous levels
  output logic      [W-1:0] o_q      // synchronised levels
);

  logic [W-1:0] meta_q;

  // the first stage is read only by the second
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= RST;
      o_q    <= RST;
    end else begin
      meta_q <= i_d;
      o_q    <= meta_q;
    end
  end

endmodule
`default_nettype wire

// >>> hdl/pwt_pot_ctrl.sv
// Notes on behaviour
// - values below full scale select tap N; zero ties wiper to B, no decrement
// - full scale and above tie wiper to A; step rules ignore as listed
// - reset loads every wiper with mid-scale for its resolution
// - terminal-control register holds A, wiper and B connect bits per network
// - shutdown bit low opens terminal A and shorts wiper to B
// - serial interface keeps working during shutdown
// - shutdown overrides connect bits without changing them
// - shutdown never touches wiper values; leaving it restores stored tap
// - each network has its own shutdown bit
// - slave only; master makes SCL, START and STOP
// - SDA is sampled on the rising SCL edge of each received bit
// - SDA change while SCL high is a START or STOP
// - works at SCL rates up to 3.4 MHz
// - never holds SCL low
// - address pin zero is latched once after reset
// - high-voltage input marks the current command as high-voltage
// - address is fixed code then pins two, one, zero; absent pins read 1
// - any STOP returns the interface to idle
// - a START resets the command state machine
`timescale 1ns/1ps
`default_nettype none
module pwt_pot_ctrl #(
  parameter int unsigned NETS     = 2,
  parameter int unsigned BITS     = 8,
  parameter logic [3:0]  DEV_CODE = 4'hA,   // arbitrary value
  parameter logic [2:0]  ADDR_PINS_PRESENT = 3'h7
) (
  input  wire logic              i_clk,                 // 125 MHz clock
  input  wire logic              i_rst_n,               // power-on reset
  input  wire logic              i_scl,                 // serial clock pin
  input  wire logic              i_sda,                 // serial data pin
  output logic                   o_sda_out,             // sda drive level
  output logic                   o_sda_oe,              // sda drive enable
  output logic                   o_scl_oe,              // scl drive enable
  input  wire logic              i_addr_pin_zero,       // address pin 0
  input  wire logic              i_addr_pin_one,        // address pin 1
  input  wire logic              i_addr_pin_two,        // address pin 2
  input  wire logic              i_high_voltage_cmd_in, // hv level seen
  output logic                   o_high_voltage_cmd,    // hv command flag
  output logic [NETS-1:0][BITS:0] o_tap,                // selected tap
  output logic [NETS-1:0]        o_wiper_at_a,          // wiper on A
  output logic [NETS-1:0]        o_wiper_at_b,          // wiper on B
  output logic [NETS-1:0]        o_term_a_conn,         // A switch closed
  output logic [NETS-1:0]        o_wiper_conn,          // W switch closed
  output logic [NETS-1:0]        o_term_b_conn,         // B switch closed
  output logic [NETS-1:0]        o_wiper_b_short,       // W tied to B
  output logic [7:0]             o_terminal_control_reg // terminal_control_reg contents
);

  localparam logic [9:0] FULL = 10'(1 << BITS);
  localparam logic [9:0] WIPER_DEF =
    (BITS == 8) ? pwt_pkg::WIPER_RESET_8 : pwt_pkg::WIPER_RESET_7;

  function automatic logic [9:0] wiper_step(input logic [9:0] v,
                                            input logic       up);
    wiper_step = v;
    if (up && v < FULL) begin
      wiper_step = v + 10'h001;
    end else if (!up && v != 10'h000 && v <= FULL) begin
      wiper_step = v - 10'h001;
    end
  endfunction

  function automatic logic cmd_valid(input logic [3:0] rg,
                                     input logic [1:0] op);
    if (rg == pwt_pkg::REG_WIPER0) begin
      cmd_valid = 1'b1;
    end else if (rg == pwt_pkg::REG_WIPER1) begin
      cmd_valid = (NETS > 1);
    end else if (rg == pwt_pkg::REG_TERMINAL_CONTROL_REG) begin
      cmd_valid = (op == pwt_pkg::OP_WRITE) || (op == pwt_pkg::OP_READ);
    end else begin
      cmd_valid = 1'b0;
    end
  endfunction

  // ---- pin synchronisers and edges
  logic [5:0] sync;
  logic       scl_s, sda_s, scl_p_q, sda_p_q;
  logic       scl_rise, scl_fall, start_det, stop_det;

  pwt_sync #(.W(6), .RST(6'h3F)) u_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_d     ({i_high_voltage_cmd_in, i_addr_pin_two, i_addr_pin_one,
               i_addr_pin_zero, i_sda, i_scl}),
    .o_q     (sync)
  );

  assign scl_s = sync[0];
  assign sda_s = sync[1];

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  assign scl_rise  = scl_s & ~scl_p_q;
  assign scl_fall  = ~scl_s & scl_p_q;
  assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_det  = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // ---- address pin zero latched after reset
  logic [1:0] cap_cnt_q;
  logic       a0_lat_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cap_cnt_q <= 2'h0;
      a0_lat_q  <= 1'b1;
    end else if (cap_cnt_q != pwt_pkg::A0_CAPTURE_AT) begin
      cap_cnt_q <= cap_cnt_q + 2'h1;
      if (cap_cnt_q + 2'h1 == pwt_pkg::A0_CAPTURE_AT) begin
        a0_lat_q <= sync[2];
      end
    end
  end

  logic [6:0] my_addr;
  assign my_addr = {DEV_CODE,
                    ADDR_PINS_PRESENT[2] ? sync[4] : 1'b1,
                    ADDR_PINS_PRESENT[1] ? sync[3] : 1'b1,
                    ADDR_PINS_PRESENT[0] ? a0_lat_q : 1'b1};

  // ---- serial state machine
  pwt_pkg::pwt_state_t state_q;
  logic [3:0] bitcnt_q;
  logic [7:0] shift_q;
  logic [1:0] phase_q;
  logic       rw_q;
  logic [3:0] reg_q;
  logic [1:0] hi_q;
  logic       rd_lo_q;
  logic       sda_oe_q;
  logic       hv_q;

  logic [NETS-1:0][9:0] wiper_q;
  logic [7:0]           terminal_control_reg_q;

  logic       rx_done;
  logic [3:0] cmd_reg;
  logic [1:0] cmd_op;
  logic       cmd_ok;
  logic       wr_go, step_go, step_up;
  logic [3:0] tgt_reg;
  logic [9:0] wr_val;
  logic [9:0] rd_val;
  logic [7:0] rd_byte;

  assign rx_done = (state_q == pwt_pkg::ST_RX) && (bitcnt_q == 4'h8)
                   && scl_fall && !start_det && !stop_det;
  assign cmd_reg = shift_q[pwt_pkg::CMD_ADDR_HI:pwt_pkg::CMD_ADDR_LO];
  assign cmd_op  = shift_q[pwt_pkg::CMD_OP_HI:pwt_pkg::CMD_OP_LO];
  assign cmd_ok  = cmd_valid(cmd_reg, cmd_op);

  always_comb begin
    wr_go   = 1'b0;
    step_go = 1'b0;
    step_up = 1'b0;
    tgt_reg = reg_q;
    wr_val  = {hi_q, shift_q};
    if (rx_done && phase_q == pwt_pkg::PH_DATA) begin
      wr_go = 1'b1;
    end else if (rx_done && phase_q == pwt_pkg::PH_CMD && cmd_ok) begin
      tgt_reg = cmd_reg;
      step_go = (cmd_op == pwt_pkg::OP_INCR) ||
                (cmd_op == pwt_pkg::OP_DECR);
      step_up = (cmd_op == pwt_pkg::OP_INCR);
    end
  end

  always_comb begin
    if (reg_q == pwt_pkg::REG_TERMINAL_CONTROL_REG) begin
      rd_val = {2'h0, terminal_control_reg_q};
    end else begin
      rd_val = wiper_q[(NETS > 1) ? int'(reg_q[0]) : 0];
    end
    rd_byte = rd_lo_q ? rd_val[7:0] : {6'h00, rd_val[9:8]};
  end

  // frames keep running whatever the shutdown bits say
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q  <= pwt_pkg::ST_IDLE;
      bitcnt_q <= 4'h0;
      shift_q  <= 8'h00;
      phase_q  <= pwt_pkg::PH_ADDR;
      rw_q     <= 1'b0;
      reg_q    <= pwt_pkg::REG_WIPER0;
      hi_q     <= 2'h0;
      rd_lo_q  <= 1'b0;
      sda_oe_q <= 1'b0;
      hv_q     <= 1'b0;
    end else if (start_det) begin
      state_q  <= pwt_pkg::ST_RX;
      bitcnt_q <= 4'h0;
      phase_q  <= pwt_pkg::PH_ADDR;
      sda_oe_q <= 1'b0;
    end else if (stop_det) begin
      state_q  <= pwt_pkg::ST_IDLE;
      sda_oe_q <= 1'b0;
      hv_q     <= 1'b0;
    end else begin
      case (state_q)
        pwt_pkg::ST_RX: begin
          if (scl_rise && bitcnt_q != 4'h8) begin
            shift_q  <= {shift_q[6:0], sda_s};
            bitcnt_q <= bitcnt_q + 4'h1;
          end else if (rx_done) begin
            if (phase_q == pwt_pkg::PH_ADDR) begin
              if (shift_q[7:1] == my_addr) begin
                state_q  <= pwt_pkg::ST_ACK;
                sda_oe_q <= 1'b1;
                rw_q     <= shift_q[0];
                rd_lo_q  <= 1'b0;
                phase_q  <= pwt_pkg::PH_CMD;
              end else begin
                state_q <= pwt_pkg::ST_IDLE;
              end
            end else if (phase_q == pwt_pkg::PH_CMD) begin
              if (cmd_ok) begin
                state_q  <= pwt_pkg::ST_ACK;
                sda_oe_q <= 1'b1;
                reg_q    <= cmd_reg;
                rd_lo_q  <= 1'b0;
                hi_q     <= shift_q[pwt_pkg::CMD_DATA_HI:0];
                hv_q     <= sync[5];
                if (cmd_op == pwt_pkg::OP_WRITE) begin
                  phase_q <= pwt_pkg::PH_DATA;
                end
              end else begin
                state_q <= pwt_pkg::ST_IDLE;
              end
            end else begin
              state_q  <= pwt_pkg::ST_ACK;
              sda_oe_q <= 1'b1;
              phase_q  <= pwt_pkg::PH_CMD;
            end
          end
        end
        pwt_pkg::ST_ACK: begin
          if (scl_fall) begin
            if (rw_q) begin
              state_q  <= pwt_pkg::ST_TX;
              sda_oe_q <= ~rd_byte[7];
              shift_q  <= {rd_byte[6:0], 1'b0};
              bitcnt_q <= 4'h1;
              rd_lo_q  <= ~rd_lo_q;
            end else begin
              state_q  <= pwt_pkg::ST_RX;
              sda_oe_q <= 1'b0;
              bitcnt_q <= 4'h0;
            end
          end
        end
        pwt_pkg::ST_TX: begin
          if (scl_fall) begin
            if (bitcnt_q == 4'h8) begin
              state_q  <= pwt_pkg::ST_MACK;
              sda_oe_q <= 1'b0;
            end else begin
              sda_oe_q <= ~shift_q[7];
              shift_q  <= {shift_q[6:0], 1'b0};
              bitcnt_q <= bitcnt_q + 4'h1;
            end
          end
        end
        pwt_pkg::ST_MACK: begin
          if (scl_rise) begin
            state_q <= sda_s ? pwt_pkg::ST_IDLE : pwt_pkg::ST_ACK;
          end
        end
        default: begin
          state_q  <= pwt_pkg::ST_IDLE;
          sda_oe_q <= 1'b0;
        end
      endcase
    end
  end

  // ---- wiper and terminal-control storage
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      terminal_control_reg_q <= pwt_pkg::TERMINAL_CONTROL_REG_RESET;
    end else if (wr_go && tgt_reg == pwt_pkg::REG_TERMINAL_CONTROL_REG) begin
      terminal_control_reg_q <= wr_val[7:0];
    end
  end

  genvar n;
  generate
    for (n = 0; n < NETS; n = n + 1) begin : g_net
      localparam int B = n * pwt_pkg::TC_NIBBLE;
      logic hw_n;
      assign hw_n = terminal_control_reg_q[B + pwt_pkg::TC_HW_N];

      // shutdown has no path into the stored wiper value
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          wiper_q[n] <= WIPER_DEF;
        end else if (wr_go && tgt_reg == 4'(n)) begin
          wiper_q[n] <= wr_val;
        end else if (step_go && tgt_reg == 4'(n)) begin
          wiper_q[n] <= wiper_step(wiper_q[n], step_up);
        end
      end

      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          o_tap[n]           <= '0;
          o_wiper_at_a[n]    <= 1'b0;
          o_wiper_at_b[n]    <= 1'b0;
          o_term_a_conn[n]   <= 1'b0;
          o_wiper_conn[n]    <= 1'b0;
          o_term_b_conn[n]   <= 1'b0;
          o_wiper_b_short[n] <= 1'b0;
        end else begin
          if (wiper_q[n] >= FULL) begin
            o_tap[n]        <= FULL[BITS:0];
            o_wiper_at_a[n] <= 1'b1;
            o_wiper_at_b[n] <= 1'b0;
          end else begin
            o_tap[n]        <= wiper_q[n][BITS:0];
            o_wiper_at_a[n] <= 1'b0;
            o_wiper_at_b[n] <= (wiper_q[n] == 10'h000);
          end
          o_term_a_conn[n]   <= hw_n & terminal_control_reg_q[B + pwt_pkg::TC_TERM_A];
          o_wiper_conn[n]    <= ~hw_n | terminal_control_reg_q[B + pwt_pkg::TC_WIPER];
          o_term_b_conn[n]   <= ~hw_n | terminal_control_reg_q[B + pwt_pkg::TC_TERM_B];
          o_wiper_b_short[n] <= ~hw_n;
        end
      end
    end
  endgenerate

  // ---- pin outputs; scl is never driven
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sda_out              <= 1'b0;
      o_sda_oe               <= 1'b0;
      o_scl_oe               <= 1'b0;
      o_high_voltage_cmd     <= 1'b0;
      o_terminal_control_reg <= pwt_pkg::TERMINAL_CONTROL_REG_RESET;
    end else begin
      o_sda_out              <= 1'b0;
      o_sda_oe               <= sda_oe_q;
      o_scl_oe               <= 1'b0;
      o_high_voltage_cmd     <= hv_q;
      o_terminal_control_reg <= terminal_control_reg_q;
    end
  end

  // ---- checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_zero_dec_hold: assert property (
    step_go && !step_up && tgt_reg == pwt_pkg::REG_WIPER0 &&
    wiper_q[0] == 10'h000 |=> wiper_q[0] == 10'h000)
    else $error("decrement at zero changed wiper");
  a_full_inc_hold: assert property (
    step_go && step_up && tgt_reg == pwt_pkg::REG_WIPER0 &&
    wiper_q[0] >= FULL |=> $stable(wiper_q[0]))
    else $error("increment at or above full scale changed wiper");
  a_above_dec_hold: assert property (
    step_go && !step_up && tgt_reg == pwt_pkg::REG_WIPER0 &&
    wiper_q[0] > FULL |=> $stable(wiper_q[0]))
    else $error("decrement above full scale changed wiper");
  a_reset_wiper_mid: assert property (
    cap_cnt_q != pwt_pkg::A0_CAPTURE_AT |-> wiper_q[0] == WIPER_DEF)
    else $error("wiper not mid-scale after reset");
  a_shutdown_opens_a: assert property (
    !terminal_control_reg_q[pwt_pkg::TC_HW_N] |=> !o_term_a_conn[0] && o_wiper_b_short[0]
    && o_wiper_conn[0] && o_term_b_conn[0])
    else $error("shutdown did not open terminal A");
  a_resume_restores: assert property (
    $rose(terminal_control_reg_q[pwt_pkg::TC_HW_N]) |=>
    o_term_a_conn[0] == terminal_control_reg_q[pwt_pkg::TC_TERM_A] && !o_wiper_b_short[0])
    else $error("connect bits not restored after shutdown");
  a_scl_never_driven: assert property (
    ##1 !o_scl_oe)
    else $error("scl driven");
  a_stop_to_idle: assert property (
    stop_det && !start_det |=> state_q == pwt_pkg::ST_IDLE ##1 !o_sda_oe)
    else $error("stop did not idle the interface");
  a_start_restarts: assert property (
    start_det |=> state_q == pwt_pkg::ST_RX && bitcnt_q == 4'h0
    && phase_q == pwt_pkg::PH_ADDR)
    else $error("start did not restart the frame");
  a_a0_latched: assert property (
    cap_cnt_q == pwt_pkg::A0_CAPTURE_AT &&
    $past(cap_cnt_q) == pwt_pkg::A0_CAPTURE_AT |-> $stable(a0_lat_q))
    else $error("latched address bit changed");

  c_wiper_write: cover property (wr_go && tgt_reg == pwt_pkg::REG_WIPER0);
  c_read_byte:   cover property (state_q == pwt_pkg::ST_MACK && scl_rise);
  c_shutdown:    cover property ($fell(terminal_control_reg_q[pwt_pkg::TC_HW_N]));
  c_step:        cover property (step_go);

endmodule
`default_nettype wire

// >>> testbench/pwt_i2c_master.sv
`timescale 1ns/1ps
`default_nettype none
// bus master: bit time of 5*Q, low for 3*Q and high for 2*Q
module pwt_i2c_master #(
  parameter int Q = 25
) (
  input  wire logic i_sda,    // bus level seen by the master
  output logic      o_scl,    // serial clock, high while idle
  output logic      o_sda_oe  // high pulls sda low
);
  initial begin
    o_scl    = 1'b1;
    o_sda_oe = 1'b0;
  end

  // a repeated start waits out the slave's acknowledge before raising scl
  task automatic start();
    #(Q);
    o_sda_oe = 1'b0;
    #(2*Q);
    o_scl = 1'b1;
    #(2*Q);
    o_sda_oe = 1'b1;
    #(2*Q);
    o_scl = 1'b0;
  endtask

  task automatic stop();
    #(Q);
    o_sda_oe = 1'b1;
    #(2*Q);
    o_scl = 1'b1;
    #(2*Q);
    o_sda_oe = 1'b0;
    #(2*Q);
  endtask

  // data moves only while scl is low
  task automatic clock_bit(input logic b, output logic r);
    #(Q);
    o_sda_oe = !b;
    #(2*Q);
    o_scl = 1'b1;
    #(Q);
    r = i_sda;
    #(Q);
    o_scl = 1'b0;
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) clock_bit(b[i], r);
    clock_bit(1'b1, r);
    ack = !r;
  endtask

  task automatic recv_byte(input logic ack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) clock_bit(1'b1, b[i]);
    clock_bit(!ack, r);
  endtask
endmodule
`default_nettype wire

// >>> testbench/tb_pwt_pot_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module tb_pwt_pot_ctrl;
  localparam logic [3:0] DEV = 4'h9;  // arbitrary value
  localparam logic [7:0] AW  = {DEV, 3'h7, 1'b0};
  logic            i_clk = 1'b0;
  logic            i_rst_n, a0, hv, m_scl, m_oe, sda_out, sda_oe, scl_oe;
  logic            hv_cmd;
  logic [1:0][8:0] tap;
  logic [1:0]      at_a, at_b, ta, tw, tbc, sh;
  logic [7:0]      terminal_control_reg;
  logic [2:0]      a;
  logic [15:0]     v;
  wire logic       sda;
  wire logic       scl;
  int              failures = 0;
  int              comparisons = 0;

  assign sda = !(sda_oe | m_oe);
  assign scl = m_scl & !scl_oe;
  always #4 i_clk = ~i_clk;

  pwt_i2c_master master_u (.i_sda(sda), .o_scl(m_scl), .o_sda_oe(m_oe));

  pwt_pot_ctrl #(.DEV_CODE(DEV)) dut_u (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_scl(scl), .i_sda(sda),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_scl_oe(scl_oe),
    .i_addr_pin_zero(a0), .i_addr_pin_one(1'b1), .i_addr_pin_two(1'b1),
    .i_high_voltage_cmd_in(hv), .o_high_voltage_cmd(hv_cmd), .o_tap(tap),
    .o_wiper_at_a(at_a), .o_wiper_at_b(at_b), .o_term_a_conn(ta),
    .o_wiper_conn(tw), .o_term_b_conn(tbc), .o_wiper_b_short(sh),
    .o_terminal_control_reg(terminal_control_reg));

  task automatic check(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // one frame: address, command and optional data byte, then stop
  task automatic put(input logic [7:0] ad, input logic [7:0] c,
                     input logic [7:0] d, input logic dat,
                     output logic [2:0] acks);
    master_u.start();
    master_u.send_byte(ad, acks[2]);
    master_u.send_byte(c, acks[1]);
    acks[0] = 1'b0;
    if (dat) master_u.send_byte(d, acks[0]);
    master_u.stop();
    repeat (4) @(posedge i_clk);
    #1;
  endtask

  task automatic wr(input logic [3:0] r, input logic [9:0] x);
    logic [2:0] k;
    put(AW, {r, pwt_pkg::OP_WRITE, x[9:8]}, x[7:0], 1'b1, k);
    check(16'(k), 16'h7, "write acks");
  endtask

  task automatic step(input logic [3:0] r, input logic [1:0] op);
    logic [2:0] k;
    put(AW, {r, op, 2'h0}, 8'h00, 1'b0, k);
    check(16'(k), 16'h6, "step acks");
  endtask

  task automatic expect_wiper(input int n, input logic [9:0] x);
    check(16'(tap[n]), (x >= 10'h100) ? 16'h100 : 16'(x), "tap");
    check(16'({at_a[n], at_b[n]}), {14'h0, x >= 10'h100, x == 10'h0}, "end");
  endtask

  task automatic expect_terms(input logic [7:0] t, input logic [7:0] exp);
    check(16'(terminal_control_reg), 16'(t), "terminal_control_reg");
    check(16'({ta, tw, tbc, sh}), 16'(exp), "terminals");
  endtask

  initial begin
    #400_000;
    failures++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    give_verdict();
  end

  initial begin
    i_rst_n = 1'b0;
    a0 = 1'b1;
    hv = 1'b0;
    repeat (4) @(posedge i_clk);
    #1 i_rst_n = 1'b1;
    repeat (6) @(posedge i_clk);
    #1 a0 = 1'b0;
    expect_terms(8'hFF, 8'hFC);
    check(16'({sda_out, scl_oe}), 16'h0, "pin drive");
    expect_wiper(0, 10'h080);
    expect_wiper(1, 10'h080);
    wr(4'h0, 10'h000);
    step(4'h0, pwt_pkg::OP_DECR);
    expect_wiper(0, 10'h000);
    step(4'h0, pwt_pkg::OP_INCR);
    expect_wiper(0, 10'h001);
    wr(4'h0, 10'h0FF);
    step(4'h0, pwt_pkg::OP_INCR);
    expect_wiper(0, 10'h100);
    step(4'h0, pwt_pkg::OP_INCR);
    expect_wiper(0, 10'h100);
    step(4'h0, pwt_pkg::OP_DECR);
    expect_wiper(0, 10'h0FF);
    wr(4'h0, 10'h3FF);
    step(4'h0, pwt_pkg::OP_INCR);
    step(4'h0, pwt_pkg::OP_DECR);
    expect_wiper(0, 10'h3FF);
    master_u.start();
    master_u.send_byte(AW, a[2]);
    master_u.send_byte({pwt_pkg::REG_WIPER0, pwt_pkg::OP_READ, 2'h0},
                       a[1]);
    master_u.start();
    master_u.send_byte(AW | 8'h01, a[0]);
    master_u.recv_byte(1'b1, v[15:8]);
    master_u.recv_byte(1'b0, v[7:0]);
    master_u.stop();
    check(16'(a), 16'h7, "read acks");
    check(v, 16'h03FF, "read wiper0");
    put(AW ^ 8'h02, 8'h00, 8'h00, 1'b1, a);
    check(16'(a), 16'h0, "a0 latched");
    put(AW, {pwt_pkg::REG_TERMINAL_CONTROL_REG, pwt_pkg::OP_INCR, 2'h0}, 8'h0, 1'b0, a);
    check(16'(a), 16'h4, "bad command");
    master_u.start();
    master_u.send_byte(AW, a[0]);
    master_u.stop();
    check(16'(a[0]), 16'h1, "address only");
    wr(pwt_pkg::REG_TERMINAL_CONTROL_REG, 10'h0F7);
    expect_terms(8'hF7, 8'hBD);
    wr(4'h0, 10'h055);
    expect_wiper(0, 10'h055);
    wr(pwt_pkg::REG_TERMINAL_CONTROL_REG, 10'h0F0);
    expect_terms(8'hF0, 8'hBD);
    wr(pwt_pkg::REG_TERMINAL_CONTROL_REG, 10'h0F8);
    expect_terms(8'hF8, 8'hA8);
    wr(pwt_pkg::REG_TERMINAL_CONTROL_REG, 10'h07F);
    expect_terms(8'h7F, 8'h7E);
    wr(pwt_pkg::REG_TERMINAL_CONTROL_REG, 10'h0FF);
    expect_wiper(0, 10'h055);
    hv = 1'b1;
    master_u.start();
    master_u.send_byte(AW, a[2]);
    master_u.send_byte(8'h70, a[1]);
    check(16'(a[1]), 16'h0, "bad register");
    master_u.start();
    master_u.send_byte(AW, a[2]);
    master_u.send_byte({pwt_pkg::REG_WIPER1, pwt_pkg::OP_WRITE, 2'h1},
                       a[1]);
    master_u.send_byte(8'h33, a[0]);
    repeat (4) @(posedge i_clk);
    #1;
    check(16'(a), 16'h7, "restart acks");
    check(16'(hv_cmd), 16'h1, "hv flag");
    master_u.stop();
    repeat (4) @(posedge i_clk);
    #1;
    check(16'(hv_cmd), 16'h0, "hv flag after stop");
    expect_wiper(1, 10'h133);
    // second reset with address pin zero low: the latch must take the pin
    i_rst_n = 1'b0;
    a0 = 1'b0;
    hv = 1'b0;
    repeat (4) @(posedge i_clk);
    #1 i_rst_n = 1'b1;
    repeat (6) @(posedge i_clk);
    #1 a0 = 1'b1;
    expect_wiper(1, 10'h080);
    expect_terms(8'hFF, 8'hFC);
    put(AW ^ 8'h02, {pwt_pkg::REG_WIPER0, pwt_pkg::OP_WRITE, 2'h0}, 8'h2A,
        1'b1, a);
    check(16'(a), 16'h7, "a0 taken from pin");
    expect_wiper(0, 10'h02A);
    master_u.start();
    master_u.send_byte(AW ^ 8'h02, a[2]);
    master_u.send_byte({pwt_pkg::REG_TERMINAL_CONTROL_REG, pwt_pkg::OP_READ, 2'h0},
                       a[1]);
    master_u.start();
    master_u.send_byte(AW ^ 8'h03, a[0]);
    master_u.recv_byte(1'b1, v[15:8]);
    master_u.recv_byte(1'b0, v[7:0]);
    master_u.stop();
    check(16'(a), 16'h7, "terminal_control_reg read acks");
    check(v, 16'h00FF, "read terminal_control_reg");
    give_verdict();
  end
endmodule
`default_nettype wire
